// ### hw/uart_lsr_pkg.sv
// Shared constants and types for the serial port line status logic
package uart_lsr_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_LSR  = 8'h00;
  localparam logic [7:0] OFS_RBR  = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_IST  = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;
  // ==========================================================
  // Line status bit positions
  localparam int LS_RX_FIFO_ERROR_FLAG = 7;
  localparam int LS_TEMT  = 6;
  localparam int LS_TX_DATA_REQUEST_FLAG  = 5;
  localparam int LS_BRK   = 4;
  localparam int LS_FE    = 3;
  localparam int LS_PE    = 2;
  localparam int LS_OE    = 1;
  localparam int LS_DR    = 0;
  // ==========================================================
  // Control register fields
  localparam int CTRL_W   = 11;
  localparam int C_FIFO   = 0;
  localparam int C_RFRST  = 1;
  localparam int C_DMA    = 2;
  localparam int C_TXIE   = 3;
  localparam int C_WLS    = 4;
  localparam int C_STOP2  = 6;
  localparam int C_PAREN  = 7;
  localparam int C_PEVEN  = 8;
  localparam int C_TRIG   = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [CTRL_W-1:0] CTRL_KEEP = 11'h7fd;
  // ==========================================================
  // Interrupt status and mask fields
  localparam int IRQ_W    = 3;
  localparam int I_RXCHAR = 0;
  localparam int I_RXERR  = 1;
  localparam int I_BREAK  = 2;
  localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;
  // ==========================================================
  // Receive buffer geometry and trigger levels, plus the transmit half-empty level
  localparam int RX_DEPTH = 16;
  localparam int PTR_W    = 4;
  localparam int CNT_W    = 5;
  localparam int ENT_W    = 12;
  localparam int E_BRK    = 8;
  localparam int E_FE     = 9;
  localparam int E_PE     = 10;
  localparam int E_OE     = 11;
  localparam logic [CNT_W-1:0] RX_FULL  = 5'h10;
  localparam logic [CNT_W-1:0] TX_HALF  = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_L0  = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_L1  = 5'h04;
  localparam logic [CNT_W-1:0] TRIG_L2  = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_L3  = 5'h0f;
  // ==========================================================
  // Receiver framing
  localparam logic [2:0] LAST_BASE  = 3'h4;
  localparam logic [3:0] CHAR_BASE  = 4'h6;
  localparam logic [3:0] LOW_SAT    = 4'hf;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_DATA = 3'b001,
    RX_PAR  = 3'b010,
    RX_STOP = 3'b011,
    RX_HOLD = 3'b100,
    RX_WAIT = 3'b101
  } rx_state_t;
endpackage

// ### hw/uart_rx_framer.sv
// Serial character receiver with parity, framing and break detection
`timescale 1ns/100ps
module uart_rx_framer
  import uart_lsr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_bit_tick,
  input  wire logic       i_rxd,
  input  wire logic [1:0] i_wls,
  input  wire logic       i_stop2,
  input  wire logic       i_par_en,
  input  wire logic       i_par_even,
  output logic            o_char_valid,
  output logic [7:0]      o_char_data,
  output logic            o_char_brk,
  output logic            o_char_fe,
  output logic            o_char_pe
);
  typedef struct packed {
    rx_state_t  state;
    logic [2:0] idx;
    logic [7:0] sh;
    logic       pbit;
    logic [3:0] low;
    logic       valid;
    logic [7:0] data;
    logic       brk;
    logic       fe;
    logic       pe;
  } rx_reg_t;

  rx_reg_t    r;
  rx_reg_t    n;
  logic [2:0] last_idx;
  logic [3:0] char_bits;
  logic       par_bad;

  assign last_idx  = LAST_BASE + {1'b0, i_wls};
  assign char_bits = CHAR_BASE + {2'b00, i_wls} + {3'b000, i_par_en} + {3'b000, i_stop2};
  assign par_bad   = i_par_en & ((^r.sh) ^ r.pbit ^ ~i_par_even); // R11

  // ==========================================================
  // Next state
  always_comb begin
    n       = r;
    n.valid = 1'b0;
    if (i_bit_tick) begin
      n.low = i_rxd ? 4'h0 : ((r.low == LOW_SAT) ? r.low : r.low + 4'h1);
      case (r.state)
        RX_IDLE: begin
          if (!i_rxd) begin
            n.state = RX_DATA;
            n.idx   = 3'h0;
            n.sh    = 8'h00;
            n.pbit  = 1'b0;
          end
        end
        RX_DATA: begin
          n.sh[r.idx] = i_rxd;
          n.idx       = r.idx + 3'h1;
          if (r.idx == last_idx) begin
            n.state = i_par_en ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          n.pbit  = i_rxd;
          n.state = RX_STOP;
        end
        RX_STOP: begin
          // Only the first stop bit is looked at; later stop time is idle
          n.data = r.sh;
          n.brk  = 1'b0;
          n.pe   = par_bad; // R11
          n.fe   = 1'b0;
          if (i_rxd) begin // R10
            n.valid = 1'b1;
            n.state = RX_IDLE;
          end else begin
            n.state = RX_HOLD;
          end
        end
        RX_HOLD: begin
          if (i_rxd) begin
            n.valid = 1'b1; // R09
            n.fe    = 1'b1;
            n.state = RX_IDLE;
          end else if (n.low > char_bits) begin
            n.valid = 1'b1; // R05
            n.data  = 8'h00; // R07
            n.brk   = 1'b1;
            n.fe    = 1'b1;
            n.pe    = 1'b0;
            n.state = RX_WAIT;
          end
        end
        RX_WAIT: begin
          if (i_rxd) begin
            n.state = RX_IDLE;
          end
        end
        default: n.state = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_char_valid = r.valid;
  assign o_char_data  = r.data;
  assign o_char_brk   = r.brk;
  assign o_char_fe    = r.fe;
  assign o_char_pe    = r.pe;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  brk_once_a: assert property (o_char_valid && o_char_brk |-> r.state == RX_WAIT) // R07
    else $error("break character left receiver outside wait");
  stop_ok_a: assert property (r.state == RX_STOP && i_bit_tick && i_rxd |=> o_char_valid && !o_char_fe) // R09
    else $error("good stop bit not reported cleanly");
  frame_bad_a: assert property (r.state == RX_HOLD && i_bit_tick && i_rxd |=> o_char_valid && o_char_fe) // R09
    else $error("low stop bit not flagged");
endmodule

// ### hw/uart_line_status.sv
// Line status, receive buffer and request logic of a serial port
// Notes on behaviour
// R01: Buffer error bit reads 1 while error characters are held, else 0 or outside FIFO mode.
// R02: Transmitter-empty bit set only when holding buffer and shifter are both empty.
// R03: Transmit request bit set at half-empty in FIFO mode, fully empty otherwise.
// R04: Transmit interrupt when enable and request set; DMA request instead when enable clear in DMA mode.
// R05: Break flagged when receive line stays low beyond one full character time.
// R06: Reading line status clears break, framing, parity and overrun flags.
// R07: One 0x00 character enters the buffer per break, however long.
// R08: In FIFO mode break, framing and parity describe the head character.
// R09: Framing error when the first bit after data or parity is low.
// R10: Only the first stop bit is checked for framing.
// R11: Parity error when received parity mismatches the odd or even selection.
// R12: Overrun when a character arrives with buffer and shifter full; it is lost.
// R13: Data ready set once a complete character is stored.
// R14: Data ready clears on non-FIFO read, empty buffer, or receive buffer reset.
// R15: Buffer error bit covers parity, framing, overrun and break, cleared once drained.
// R16: In DMA mode buffer error raises error interrupt and blocks receive DMA requests.
// R17: Software reads line status before reading the erroneous character.
// R18: Line status is read-only; clear-on-read acts once per completed read.
`timescale 1ns/100ps
module uart_line_status
  import uart_lsr_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_rxd,
  input  wire logic        i_bit_tick,
  input  wire logic [4:0]  i_tx_level,
  input  wire logic        i_tx_shift_busy,
  output logic             o_irq,
  output logic             o_tx_irq,
  output logic             o_tx_dma_req,
  output logic             o_rx_dma_req,
  output logic             o_rx_err_irq
);
  typedef struct packed {
    logic [RX_DEPTH-1:0][ENT_W-1:0] ent;
    logic [PTR_W-1:0]  rd_ptr;
    logic [PTR_W-1:0]  wr_ptr;
    logic [CNT_W-1:0]  count;
    logic              head_seen;
    logic              overrun;
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0]  ist;
    logic [IRQ_W-1:0]  imask;
    logic              ph_wr;
    logic [7:0]        ph_addr;
    logic [31:0]       rdata;
  } lsr_state_t;

  lsr_state_t        s;
  lsr_state_t        n;

  logic              c_valid;
  logic [7:0]        c_data;
  logic              c_brk;
  logic              c_fe;
  logic              c_pe;

  logic              fifo_mode;
  logic              dma_mode;
  logic              tx_ie;
  logic              have_char;
  logic [ENT_W-1:0]  head;
  logic              cap_full;
  logic [RX_DEPTH-1:0] err_vec;
  logic              fifo_err;
  logic              tx_data_request_flag;
  logic              temt;
  logic [CNT_W-1:0]  trig;
  logic [7:0]        lsr;
  logic              take;
  logic              rd_take;
  logic              lsr_rd;
  logic              pop;
  logic              push;
  logic              ovr;
  logic              wr_ctrl;
  logic              flush;
  logic [31:0]       rd_val;
  logic [IRQ_W-1:0]  ev;

  // ==========================================================
  // Character receiver
  uart_rx_framer u_rx (
    .i_clk        (i_clk),
    .i_reset_n    (i_reset_n),
    .i_bit_tick   (i_bit_tick),
    .i_rxd        (i_rxd),
    .i_wls        (s.ctrl[C_WLS+:2]),
    .i_stop2      (s.ctrl[C_STOP2]),
    .i_par_en     (s.ctrl[C_PAREN]),
    .i_par_even   (s.ctrl[C_PEVEN]),
    .o_char_valid (c_valid),
    .o_char_data  (c_data),
    .o_char_brk   (c_brk),
    .o_char_fe    (c_fe),
    .o_char_pe    (c_pe)
  );

  // ==========================================================
  // Status terms
  assign fifo_mode = s.ctrl[C_FIFO];
  assign dma_mode  = s.ctrl[C_DMA];
  assign tx_ie     = s.ctrl[C_TXIE];
  assign have_char = s.count != '0;
  assign head      = s.ent[s.rd_ptr];
  // Outside FIFO mode the buffer behaves as a single holding slot
  assign cap_full  = fifo_mode ? (s.count == RX_FULL) : have_char;

  // Any held entry that carries an error
  for (genvar g = 0; g < RX_DEPTH; g++) begin : g_err
    logic [PTR_W-1:0] off;
    assign off        = PTR_W'(g) - s.rd_ptr;
    assign err_vec[g] = ({1'b0, off} < s.count) & (|s.ent[g][E_OE:E_BRK]); // R15
  end

  assign fifo_err = fifo_mode & (|err_vec); // R01
  assign tx_data_request_flag     = fifo_mode ? (i_tx_level <= TX_HALF) : (i_tx_level == '0); // R03
  assign temt     = (i_tx_level == '0) & ~i_tx_shift_busy; // R02

  always_comb begin
    case (s.ctrl[C_TRIG+:2])
      2'h0:    trig = TRIG_L0;
      2'h1:    trig = TRIG_L1;
      2'h2:    trig = TRIG_L2;
      default: trig = TRIG_L3;
    endcase
  end

  // Head flags stay visible until a status read or until the head leaves
  always_comb begin
    lsr           = 8'h00;
    lsr[LS_RX_FIFO_ERROR_FLAG] = fifo_err;
    lsr[LS_TEMT]  = temt;
    lsr[LS_TX_DATA_REQUEST_FLAG]  = tx_data_request_flag;
    if (have_char && !s.head_seen) begin
      lsr[LS_BRK] = head[E_BRK]; // R08
      lsr[LS_FE]  = head[E_FE];
      lsr[LS_PE]  = head[E_PE];
    end
    lsr[LS_OE]    = s.overrun;
    lsr[LS_DR]    = have_char; // R13
  end

  // ==========================================================
  // Bus decode
  assign take    = i_hsel & i_htrans[1] & i_hready;
  assign rd_take = take & ~i_hwrite;
  // Zero wait states: the read side effect lands with the address phase
  assign lsr_rd  = rd_take & (i_haddr[7:0] == OFS_LSR); // R18
  assign pop     = rd_take & (i_haddr[7:0] == OFS_RBR) & have_char; // R14
  assign push    = c_valid & ~cap_full;
  assign ovr     = c_valid & cap_full; // R12
  assign wr_ctrl = s.ph_wr & (s.ph_addr == OFS_CTRL);
  // Changing the buffer mode also empties the buffer
  assign flush   = wr_ctrl & (i_hwdata[C_RFRST] | (i_hwdata[C_FIFO] != fifo_mode)); // R14
  assign ev      = {c_valid & c_brk, ovr | (push & (c_fe | c_pe | c_brk)), push};

  always_comb begin
    rd_val = 32'h0000_0000;
    if (i_haddr[7:0] == OFS_LSR) begin
      rd_val[7:0] = lsr;
    end else if (i_haddr[7:0] == OFS_RBR) begin
      rd_val[7:0] = have_char ? head[7:0] : 8'h00;
    end else if (i_haddr[7:0] == OFS_CTRL) begin
      rd_val[CTRL_W-1:0] = s.ctrl;
    end else if (i_haddr[7:0] == OFS_IST) begin
      rd_val[IRQ_W-1:0] = s.ist;
    end else if (i_haddr[7:0] == OFS_MASK) begin
      rd_val[IRQ_W-1:0] = s.imask;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    n       = s;
    n.ph_wr = take & i_hwrite;
    if (take) begin
      n.ph_addr = i_haddr[7:0];
    end
    if (rd_take) begin
      n.rdata = rd_val;
    end

    if (lsr_rd) begin
      n.overrun   = 1'b0; // R06
      n.head_seen = have_char;
    end
    if (pop) begin
      n.rd_ptr    = s.rd_ptr + PTR_W'(1);
      n.head_seen = 1'b0;
    end
    if (push) begin
      n.ent[s.wr_ptr] = {1'b0, c_pe, c_fe, c_brk, c_data};
      n.wr_ptr        = s.wr_ptr + PTR_W'(1);
    end
    if (ovr) begin
      // New data is dropped; the newest held character carries the mark
      n.overrun                        = 1'b1; // R12
      n.ent[s.wr_ptr - PTR_W'(1)][E_OE] = 1'b1; // R15
    end
    n.count = s.count + {4'h0, push} - {4'h0, pop};

    if (flush) begin
      n.rd_ptr = '0;
      n.wr_ptr = '0;
      n.count  = '0;
    end
    if (n.count == '0) begin
      n.head_seen = 1'b0;
    end

    // Sticky events: a new event wins over a clear in the same cycle
    n.ist = s.ist;
    if (s.ph_wr && s.ph_addr == OFS_IST) begin
      n.ist = s.ist & ~i_hwdata[IRQ_W-1:0];
    end
    n.ist = n.ist | ev;
    if (wr_ctrl) begin
      n.ctrl = i_hwdata[CTRL_W-1:0] & CTRL_KEEP;
    end
    if (s.ph_wr && s.ph_addr == OFS_MASK) begin
      n.imask = i_hwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s       <= '0;
      s.ctrl  <= CTRL_RST;
      s.imask <= IMASK_RST;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign o_hrdata     = s.rdata;
  assign o_hreadyout  = 1'b1;
  assign o_hresp      = 1'b0;
  assign o_irq        = |(s.ist & s.imask);
  assign o_tx_irq     = tx_ie & tx_data_request_flag; // R04
  assign o_tx_dma_req = dma_mode & ~tx_ie & tx_data_request_flag; // R04
  assign o_rx_dma_req = dma_mode & (s.count >= trig) & ~fifo_err; // R16
  assign o_rx_err_irq = dma_mode & fifo_err; // R16

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  rx_fifo_error_flag_off_a: assert property (!fifo_mode |-> !lsr[LS_RX_FIFO_ERROR_FLAG]) // R01
    else $error("buffer error shown outside FIFO mode");
  temt_src_a: assert property (lsr[LS_TEMT] |-> i_tx_level == '0 && !i_tx_shift_busy) // R02
    else $error("transmitter empty while data held");
  tx_data_request_flag_plain_a: assert property (!fifo_mode |-> lsr[LS_TX_DATA_REQUEST_FLAG] == (i_tx_level == '0)) // R03
    else $error("transmit request wrong in plain mode");
  tx_dma_a: assert property (o_tx_dma_req |-> dma_mode && !o_tx_irq && lsr[LS_TX_DATA_REQUEST_FLAG]) // R04
    else $error("transmit DMA request without cause");
  lsr_clear_a: assert property (lsr_rd && !c_valid ##1 !flush |-> !s.overrun && !lsr[LS_BRK]) // R06
    else $error("status read did not clear error flags");
  head_flag_a: assert property (lsr[LS_FE] |-> have_char && head[E_FE]) // R08
    else $error("framing flag not from head character");
  ovr_set_a: assert property (c_valid && cap_full && !pop && !flush |=> s.overrun && $stable(s.count)) // R12
    else $error("overrun not flagged or data stored");
  dr_set_a: assert property (c_valid && !cap_full && !flush |=> lsr[LS_DR]) // R13
    else $error("data ready missing after store");
  dr_pop_a: assert property (pop && !fifo_mode && !c_valid && !flush |=> !lsr[LS_DR]) // R14
    else $error("data ready held after plain read");
  rx_dma_a: assert property (fifo_err |-> !o_rx_dma_req && (o_rx_err_irq == dma_mode)) // R16
    else $error("receive DMA not blocked by buffer error");

  push_c: cover property (c_valid && !cap_full ##1 pop);
  ovr_c: cover property (fifo_mode && c_valid && cap_full);
  brk_c: cover property (push && c_brk ##[1:20] lsr_rd);
  txirq_c: cover property (o_tx_irq ##1 !o_tx_irq);
endmodule

// ### sim/uart_remote_model.sv
// Remote serial transmitter driving the receive line and bit sample ticks
`timescale 1ns/100ps
module uart_remote_model (
  input  wire logic i_clk,
  output logic      o_rxd,
  output logic      o_bit_tick
);
  // ==========================================================
  // Bit timing
  // Eight clocks a bit with the tick at mid-bit; ticks stand still between frames
  initial begin
    o_rxd      = 1'b1;
    o_bit_tick = 1'b0;
  end
  task automatic bit_out(input logic b);
    o_rxd <= b;
    repeat (3) @(posedge i_clk);
    o_bit_tick <= 1'b1;
    @(posedge i_clk);
    o_bit_tick <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  // ==========================================================
  // Frames
  // A low stop bit is followed by one idle bit so the receiver can settle it
  task automatic send_char(input logic [7:0] d, input int nb, input logic pen, input logic pb, input logic stp);
    bit_out(1'b0);
    for (int i = 0; i < nb; i++) begin
      bit_out(d[i]);
    end
    if (pen) begin
      bit_out(pb);
    end
    bit_out(stp);
    if (!stp) begin
      bit_out(1'b1);
    end
  endtask
  task automatic send_break(input int n);
    repeat (n) bit_out(1'b0);
    bit_out(1'b1);
  endtask
endmodule

// ### sim/tb.sv
// Self-checking bench for the line status logic
`timescale 1ns/100ps
module tb
  import uart_lsr_pkg::*;
;
  logic        clk;
  logic        reset_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        rxd;
  logic        tick;
  logic [4:0]  tx_level;
  logic        tx_busy;
  logic        irq;
  logic        tx_irq;
  logic        tx_dma;
  logic        rx_dma;
  logic        rx_err;
  int          n_fail;
  int          check_count;
  logic [31:0] rd;
  logic [7:0]  d1;
  logic [7:0]  d2;
  logic [4:0]  lv;
  logic [3:0]  mode;
  logic        pb;
  logic        tx_data_request_flag;

  uart_line_status DUT (
    .i_clk(clk), .i_reset_n(reset_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(), .i_rxd(rxd), .i_bit_tick(tick), .i_tx_level(tx_level),
    .i_tx_shift_busy(tx_busy), .o_irq(irq), .o_tx_irq(tx_irq), .o_tx_dma_req(tx_dma),
    .o_rx_dma_req(rx_dma), .o_rx_err_irq(rx_err)
  );
  uart_remote_model remote (.i_clk(clk), .o_rxd(rxd), .o_bit_tick(tick));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================
  // Checks and bus cycles
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= w ? wd : 32'h00000000;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    // Select stays up with the bus idle, so a following call never drives it twice in one step
    r = hrdata;
  endtask
  // The idle edge after a write lets it land before the next read
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h00000000, rd);
    chk(rd, e, m);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    complete_run;
  end

  // ==========================================================
  // Scenarios
  initial begin
    reset_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hwdata = 32'h0; tx_level = 5'h00; tx_busy = 1'b0; n_fail = 0; check_count = 0;
    void'($urandom(19));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdc(OFS_LSR, 32'h60, "status after reset");
    rdc(OFS_CTRL, 32'h0, "ctrl reset");
    rdc(OFS_MASK, 32'h0, "mask reset");
    wr(OFS_LSR, 32'hff);
    rdc(OFS_LSR, 32'h60, "status write");
    rdc(8'h20, 32'h0, "unmapped read");
    for (int i = 0; i < 16; i++) begin
      lv = (i < 3) ? 5'(i * 8) : 5'($urandom_range(16, 0));
      mode = 4'($urandom);
      tx_level <= lv;
      tx_busy <= mode[1];
      wr(OFS_CTRL, 32'h30 | {28'h0, mode[3], mode[2], 1'b0, mode[0]});
      tx_data_request_flag = mode[0] ? (lv <= TX_HALF) : (lv == 5'h00);
      rdc(OFS_LSR, {25'h0, (lv == 5'h00) && !mode[1], tx_data_request_flag, 5'h0}, "tx flags");
      chk(tx_irq, mode[3] & tx_data_request_flag, "tx irq");
      chk(tx_dma, mode[2] & ~mode[3] & tx_data_request_flag, "tx dma");
    end
    tx_level <= 5'h00;
    tx_busy <= 1'b0;
    wr(OFS_CTRL, 32'h30);
    wr(OFS_MASK, 32'h0);
    d1 = 8'($urandom);
    remote.send_char(d1, 8, 1'b0, 1'b0, 1'b1);
    rdc(OFS_IST, 32'h1, "char event");
    chk(irq, 1'b0, "masked irq");
    wr(OFS_MASK, 32'h7);
    chk(irq, 1'b1, "irq raised");
    wr(OFS_IST, 32'h7);
    chk(irq, 1'b0, "irq cleared");
    rdc(OFS_LSR, 32'h61, "data ready");
    rdc(OFS_RBR, {24'h0, d1}, "rx data");
    rdc(OFS_LSR, 32'h60, "ready after read");
    d2 = ~d1;
    remote.send_char(d1, 8, 1'b0, 1'b0, 1'b1);
    remote.send_char(d2, 8, 1'b0, 1'b0, 1'b1);
    rdc(OFS_LSR, 32'h63, "overrun");
    rdc(OFS_LSR, 32'h61, "overrun after read");
    rdc(OFS_RBR, {24'h0, d1}, "first char kept");
    for (int i = 0; i < 4; i++) begin
      d1 = 8'($urandom);
      pb = (i[0] ? ^d1 : ~^d1) ^ i[1];
      wr(OFS_CTRL, 32'hb0 | (32'(i[0]) << 8));
      remote.send_char(d1, 8, 1'b1, pb, 1'b1);
      rdc(OFS_LSR, 32'h61 | (32'(i[1]) << 2), "parity flag");
      rdc(OFS_LSR, 32'h61, "parity after read");
      rdc(OFS_RBR, {24'h0, d1}, "parity char");
    end
    // Five-bit word with two stop bits selected; only the first stop bit is checked
    wr(OFS_CTRL, 32'h40);
    remote.send_char(d1, 5, 1'b0, 1'b0, 1'b1);
    rdc(OFS_LSR, 32'h61, "two stop bits");
    rdc(OFS_RBR, {27'h0, d1[4:0]}, "short char");
    wr(OFS_CTRL, 32'h30);
    remote.send_char(d1, 8, 1'b0, 1'b0, 1'b0);
    rdc(OFS_LSR, 32'h69, "framing flag");
    rdc(OFS_RBR, {24'h0, d1}, "framing char");
    wr(OFS_CTRL, 32'h1b1);
    d2 = 8'($urandom);
    remote.send_char(d1, 8, 1'b1, ^d1, 1'b1);
    remote.send_char(d2, 8, 1'b1, ~^d2, 1'b1);
    rdc(OFS_LSR, 32'he1, "head good");
    rdc(OFS_RBR, {24'h0, d1}, "fifo head");
    rdc(OFS_LSR, 32'he5, "head bad");
    rdc(OFS_RBR, {24'h0, d2}, "fifo second");
    rdc(OFS_LSR, 32'h60, "fifo drained");
    // Trigger level one, so only the error holds the receive request back
    wr(OFS_CTRL, 32'h35);
    remote.send_break(30);
    @(negedge clk);
    chk(rx_err, 1'b1, "error irq");
    chk(rx_dma, 1'b0, "rx dma held");
    @(posedge clk);
    rdc(OFS_LSR, 32'hf9, "break flags");
    rdc(OFS_RBR, 32'h0, "break char");
    rdc(OFS_LSR, 32'h60, "one break char");
    remote.send_char(d2, 8, 1'b0, 1'b0, 1'b1);
    @(negedge clk);
    chk(rx_err, 1'b0, "error irq gone");
    chk(rx_dma, 1'b1, "rx dma");
    @(posedge clk);
    wr(OFS_CTRL, 32'h37);
    rdc(OFS_LSR, 32'h60, "buffer reset");
    complete_run;
  end
endmodule
